// ===== core/can_scb_pkg.sv
// Purpose: shared constants for the CAN status, counter and baud block
// Assumes: 8-bit CPU data, 16-bit CPU address, one clock domain
// Notes:   addresses are CPU byte addresses of 8-bit registers
package can_scb_pkg;
   // register addresses
   localparam logic [15:0] ADDR_ERROR_STATUS  = 16'hFFB4;
   localparam logic [15:0] ADDR_TX_ERR_COUNT  = 16'hFFB5;
   localparam logic [15:0] ADDR_RX_ERR_COUNT  = 16'hFFB6;
   localparam logic [15:0] ADDR_RX_BUF_COUNT  = 16'hFFB7;
   localparam logic [15:0] ADDR_PRESCALER     = 16'hFFB8;

   // reset values
   localparam logic [7:0]  RST_RX_BUF_COUNT   = 8'hC0;
   localparam logic [7:0]  RST_PRESCALER      = 8'h3F;
   localparam logic [7:0]  RST_ERR_COUNT      = 8'h00;

   // error status field positions
   localparam int          ES_OVER            = 0;
   localparam int          ES_WAKE            = 1;
   localparam int          ES_VALID           = 2;
   localparam int          ES_INIT_CONFIRMED  = 3;
   localparam int          ES_TECS            = 5;
   localparam int          ES_RECS            = 6;
   localparam int          ES_BOFF            = 7;

   // receive buffer count field position and count ceiling
   localparam int          RB_PM_RESET        = 5;
   localparam logic [4:0]  RB_COUNT_MAX       = 5'h10;

   // error counter figures
   localparam logic [7:0]  ERR_WARN_LEVEL     = 8'h60;
   localparam logic [7:0]  ERR_PASSIVE_LEVEL  = 8'h7F;
   localparam logic [7:0]  REC_PASSIVE_BACK   = 8'h77;
   localparam logic [7:0]  ERR_STEP_BIG       = 8'h08;

   // clock source select encodings
   typedef enum logic [1:0] {
      SRC_SYS,
      SRC_SYS_DIV2,
      SRC_SYS_DIV4,
      SRC_ALT
   } clk_src_e;

   // controller clocks per time quantum, narrow or wide prescaler mode
   function automatic logic [8:0] clocks_per_tq(input logic       wide,
                                                input logic [7:0] value);
      if (wide) begin
         clocks_per_tq = {1'b0, value} + 9'h001;
      end else begin
         clocks_per_tq = {2'b00, value[5:0], 1'b0} + 9'h002;
      end
   endfunction : clocks_per_tq
endpackage : can_scb_pkg

// ===== core/can_tq_gen.sv
// Purpose: controller clock enable and time quantum tick generator
// Assumes: alternate clock is far slower than core_clk
// Notes:   the selected source becomes a clock enable, not a real clock
`timescale 1ns/1ps
module can_tq_gen (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic [1:0] clock_source_sel,
   input  wire logic       prescaler_wide_mode,
   input  wire logic [7:0] prescale_value,
   input  wire logic       alternate_clock_input,
   output logic            ctrl_clk_en_q,
   output logic            tq_tick_q
);
   logic [2:0] alt_sync_q;
   logic [1:0] div_q;
   logic [8:0] tq_cnt_q;
   logic       en_d;
   logic [8:0] per_tq;

   // two-flop synchroniser then edge history; stages 2 and 3 feed the edge detect
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         alt_sync_q <= 3'h0;
      end else begin
         alt_sync_q <= {alt_sync_q[1:0], alternate_clock_input};
      end
   end

   // free divider for the halved and quartered system clock
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end

   // source choice, one enable per controller clock
   always_comb begin
      case (can_scb_pkg::clk_src_e'(clock_source_sel))
         can_scb_pkg::SRC_SYS:      en_d = 1'b1;
         can_scb_pkg::SRC_SYS_DIV2: en_d = div_q[0];
         can_scb_pkg::SRC_SYS_DIV4: en_d = (div_q == 2'h3);
         can_scb_pkg::SRC_ALT:      en_d = alt_sync_q[1] & ~alt_sync_q[2];
         default:                   en_d = 1'b0;
      endcase
   end

   assign per_tq = can_scb_pkg::clocks_per_tq(prescaler_wide_mode, prescale_value);

   // quantum counter; tick on the last controller clock of each quantum
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tq_cnt_q      <= 9'h000;
         tq_tick_q     <= 1'b0;
         ctrl_clk_en_q <= 1'b0;
      end else begin
         ctrl_clk_en_q <= en_d;
         tq_tick_q     <= 1'b0;
         if (en_d) begin
            if (tq_cnt_q + 9'h001 >= per_tq) begin
               tq_cnt_q  <= 9'h000;
               tq_tick_q <= 1'b1;
            end else begin
               tq_cnt_q <= tq_cnt_q + 9'h001;
            end
         end
      end
   end
endmodule : can_tq_gen

// ===== core/can_status_count_baud_config.sv
// Purpose: CAN error status flags, error counters, buffer count, prescaler
// Assumes: protocol machine events are one-cycle pulses on core_clk
// Notes:   CPU access is 8-bit; reads return data one cycle later
//
// Summary of operation
// - wake flag cleared by one or init
// - writing zero leaves wake flag alone
// - overrun sets flag and error interrupt together
// - fetch overrun keeps send request, retransmits
// - late store: no receive flags raised
// - late id fetch drops the message
// - read-only transmit error counter, reset zero
// - read-only receive error counter, reset zero
// - buffer count above sixteen forced sixteen
// - machine reset in bus-off enters init
// - clock source select picks controller clock
// - low six bits set quantum length
// - narrow mode: two times value plus two
// - wide mode: eight-bit value plus one
// - init confirmation waits for idle activity
// - internal set beats CPU clear
`timescale 1ns/1ps
module can_status_count_baud_config (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   input  wire logic [7:0]  cpu_wdata,
   output logic [7:0]       cpu_rdata_q,
   input  wire logic        init_request,
   input  wire logic        activity_idle,
   input  wire logic        wake_event,
   input  wire logic        valid_event,
   input  wire logic        tx_fetch_overrun,
   input  wire logic        rx_store_overrun,
   input  wire logic        id_fetch_overrun,
   input  wire logic        tx_error,
   input  wire logic        tx_success,
   input  wire logic        rx_error,
   input  wire logic        rx_error_big,
   input  wire logic        rx_success,
   input  wire logic        bus_idle_recovered,
   input  wire logic        prescaler_wide_mode,
   input  wire logic [1:0]  prescale_upper,
   input  wire logic        alternate_clock_input,
   output logic             error_irq_q,
   output logic             init_force_q,
   output logic             keep_send_request_q,
   output logic             retransmit_q,
   output logic             rx_flags_block_q,
   output logic             rx_drop_q,
   output logic [4:0]       rx_buffer_count_q,
   output logic             ctrl_clk_en_q,
   output logic             tq_tick_q
);
   logic [7:0] tec_q;
   logic [7:0] rec_q;
   logic [7:0] rbc_q;
   logic [7:0] presc_q;
   logic       over_q;
   logic       wake_q;
   logic       valid_q;
   logic       boff_q;
   logic       init_conf_q;
   logic       init_req_prev_q;
   logic       init_rise;
   logic       wr_status;
   logic       pm_reset;
   logic       over_set;
   logic       over_d;
   logic       wake_d;
   logic [8:0] tec_sum;

   assign wr_status = cpu_wr && (cpu_addr == can_scb_pkg::ADDR_ERROR_STATUS);
   assign init_rise = init_request & ~init_req_prev_q;
   assign over_set  = tx_fetch_overrun | rx_store_overrun | id_fetch_overrun;
   assign pm_reset  = cpu_wr && (cpu_addr == can_scb_pkg::ADDR_RX_BUF_COUNT)
                      && cpu_wdata[can_scb_pkg::RB_PM_RESET] && boff_q;

   // set terms last so a same-cycle clear loses
   always_comb begin
      over_d = over_q;
      wake_d = wake_q;
      if (wr_status && cpu_wdata[can_scb_pkg::ES_OVER]) begin
         over_d = 1'b0;
      end
      if ((wr_status && cpu_wdata[can_scb_pkg::ES_WAKE]) || init_rise) begin
         wake_d = 1'b0;
      end
      if (over_set) begin
         over_d = 1'b1;
      end
      if (wake_event) begin
         wake_d = 1'b1;
      end
   end

   // sticky status flags and the error interrupt level
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         over_q          <= 1'b0;
         wake_q          <= 1'b0;
         valid_q         <= 1'b0;
         error_irq_q     <= 1'b0;
         init_req_prev_q <= 1'b0;
      end else begin
         init_req_prev_q <= init_request;
         over_q          <= over_d;
         wake_q          <= wake_d;
         error_irq_q     <= over_d | wake_d;
         if (valid_event) begin
            valid_q <= 1'b1;
         end else if ((wr_status && cpu_wdata[can_scb_pkg::ES_VALID]) || init_rise) begin
            valid_q <= 1'b0;
         end
      end
   end

   // init confirmation follows request only once activity has settled
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         init_conf_q  <= 1'b0;
         init_force_q <= 1'b0;
      end else begin
         init_force_q <= pm_reset;
         if (pm_reset) begin
            init_conf_q <= 1'b1;
         end else if (activity_idle && !(init_request && boff_q)) begin
            init_conf_q <= init_request;
         end
      end
   end

   assign tec_sum = {1'b0, tec_q} + {1'b0, can_scb_pkg::ERR_STEP_BIG};

   // transmit counter and bus-off; saturates at 255, overflow means bus-off
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tec_q  <= can_scb_pkg::RST_ERR_COUNT;
         boff_q <= 1'b0;
      end else if (pm_reset || (boff_q && bus_idle_recovered)) begin
         tec_q  <= can_scb_pkg::RST_ERR_COUNT;
         boff_q <= 1'b0;
      end else if (!boff_q) begin
         if (tx_error) begin
            tec_q <= tec_sum[8] ? 8'hFF : tec_sum[7:0];
            if (tec_sum[8]) begin
               boff_q <= 1'b1;
            end
         end else if (tx_success && tec_q != 8'h00) begin
            tec_q <= tec_q - 8'h01;
         end
      end
   end

   // receive counter; success above passive level drops back into range
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rec_q <= can_scb_pkg::RST_ERR_COUNT;
      end else if (pm_reset) begin
         rec_q <= can_scb_pkg::RST_ERR_COUNT;
      end else if (rx_error_big) begin
         rec_q <= (rec_q > 8'hF7) ? 8'hFF : rec_q + can_scb_pkg::ERR_STEP_BIG;
      end else if (rx_error) begin
         rec_q <= (rec_q == 8'hFF) ? 8'hFF : rec_q + 8'h01;
      end else if (rx_success) begin
         if (rec_q > can_scb_pkg::ERR_PASSIVE_LEVEL) begin
            rec_q <= can_scb_pkg::REC_PASSIVE_BACK;
         end else if (rec_q != 8'h00) begin
            rec_q <= rec_q - 8'h01;
         end
      end
   end

   // config registers; writes outside confirmed init are ignored
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rbc_q   <= can_scb_pkg::RST_RX_BUF_COUNT;
         presc_q <= can_scb_pkg::RST_PRESCALER;
      end else if (cpu_wr && init_conf_q) begin
         if (cpu_addr == can_scb_pkg::ADDR_RX_BUF_COUNT) begin
            rbc_q[7:6] <= cpu_wdata[7:6];
            rbc_q[5]   <= 1'b0;
            rbc_q[4:0] <= cpu_wdata[4] ? can_scb_pkg::RB_COUNT_MAX : cpu_wdata[4:0];
         end
         if (cpu_addr == can_scb_pkg::ADDR_PRESCALER) begin
            presc_q <= cpu_wdata;
         end
      end
   end

   // overrun reactions handed to the protocol machine
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         keep_send_request_q <= 1'b0;
         retransmit_q        <= 1'b0;
         rx_flags_block_q    <= 1'b0;
         rx_drop_q           <= 1'b0;
      end else begin
         retransmit_q     <= tx_fetch_overrun;
         rx_flags_block_q <= rx_store_overrun;
         rx_drop_q        <= id_fetch_overrun;
         if (tx_fetch_overrun) begin
            keep_send_request_q <= 1'b1;
         end else if (tx_success) begin
            keep_send_request_q <= 1'b0;
         end
      end
   end

   // registered read data; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_rdata_q <= 8'h00;
      end else if (cpu_rd) begin
         case (cpu_addr)
            can_scb_pkg::ADDR_ERROR_STATUS:
               cpu_rdata_q <= {boff_q, rec_q >= can_scb_pkg::ERR_WARN_LEVEL,
                               tec_q >= can_scb_pkg::ERR_WARN_LEVEL, 1'b0,
                               init_conf_q, valid_q, wake_q, over_q};
            can_scb_pkg::ADDR_TX_ERR_COUNT: cpu_rdata_q <= tec_q;
            can_scb_pkg::ADDR_RX_ERR_COUNT: cpu_rdata_q <= rec_q;
            can_scb_pkg::ADDR_RX_BUF_COUNT: cpu_rdata_q <= rbc_q;
            can_scb_pkg::ADDR_PRESCALER:    cpu_rdata_q <= presc_q;
            default:                        cpu_rdata_q <= 8'h00;
         endcase
      end
   end

   assign rx_buffer_count_q = rbc_q[4:0];

   // quantum generator; upper prescale bits come from mask control
   can_tq_gen u_tq_gen (
      .core_clk              (core_clk),
      .rstn                  (rstn),
      .clock_source_sel      (presc_q[7:6]),
      .prescaler_wide_mode   (prescaler_wide_mode),
      .prescale_value        ({prescale_upper, presc_q[5:0]}),
      .alternate_clock_input (alternate_clock_input),
      .ctrl_clk_en_q         (ctrl_clk_en_q),
      .tq_tick_q             (tq_tick_q)
   );
endmodule : can_status_count_baud_config

// ===== verif/scb_checker_asserts.sv
// Purpose: port checks for can_status_count_baud_config
// Assumes: one clock domain, event inputs are one-cycle pulses
// Notes:   status flags are visible here only through error_irq_q
`timescale 1ns/1ps
module scb_checker (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_wr,
   input wire logic        init_request,
   input wire logic        tx_fetch_overrun,
   input wire logic        rx_store_overrun,
   input wire logic        id_fetch_overrun,
   input wire logic        tx_success,
   input wire logic        error_irq_q,
   input wire logic        init_force_q,
   input wire logic        keep_send_request_q,
   input wire logic        retransmit_q,
   input wire logic        rx_flags_block_q,
   input wire logic        rx_drop_q,
   input wire logic [4:0]  rx_buffer_count_q
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // status write: besides rising init, the only way a flag may fall
   logic st_wr;
   assign st_wr = cpu_wr && (cpu_addr == can_scb_pkg::ADDR_ERROR_STATUS);

   over_irq_a: assert property (tx_fetch_overrun |=> error_irq_q)
      else $error("overrun left the interrupt low");
   irq_hold_a: assert property (
      error_irq_q && !st_wr && !$rose(init_request) |=> error_irq_q)
      else $error("interrupt fell without a clear");
   resend_a: assert property (
      tx_fetch_overrun |=> retransmit_q && keep_send_request_q)
      else $error("fetch overrun gave no retransmit");
   keep_hold_a: assert property (
      keep_send_request_q && !tx_success |=> keep_send_request_q)
      else $error("send request lost before success");
   keep_clear_a: assert property (
      tx_success && !tx_fetch_overrun |=> !keep_send_request_q)
      else $error("send request kept after success");
   rx_block_a: assert property (rx_store_overrun |=> rx_flags_block_q)
      else $error("late store did not block flags");
   rx_drop_a: assert property (id_fetch_overrun |=> rx_drop_q)
      else $error("late compare did not drop message");
   pm_pulse_a: assert property (init_force_q |=> !init_force_q)
      else $error("init force longer than one cycle");
   count_cap_a: assert property (rx_buffer_count_q <= 5'h10)
      else $error("buffer count above sixteen");

   c_resend: cover property (tx_fetch_overrun ##1 retransmit_q);
   c_pm_reset: cover property (init_force_q);
   c_full: cover property (rx_buffer_count_q == 5'h10);
endmodule : scb_checker

bind can_status_count_baud_config scb_checker chk_i (.core_clk, .rstn, .cpu_addr, .cpu_wr,
   .init_request, .tx_fetch_overrun, .rx_store_overrun, .id_fetch_overrun, .tx_success,
   .error_irq_q, .init_force_q, .keep_send_request_q, .retransmit_q, .rx_flags_block_q,
   .rx_drop_q, .rx_buffer_count_q);

// ===== verif/can_node_model.sv
// Purpose: far-side stand-in: bus events and the alternate clock pin
// Assumes: events are seen by the block as one-cycle pulses
// Notes:   ev order: wake valid txfo rxso idfo txerr txok rxerr rxbig rxok idle
`timescale 1ns/1ps
module can_node_model (
   input  wire logic        core_clk,
   output logic [10:0]      ev,
   output logic             alt_clk
);
   initial begin
      ev = '0;
      alt_clk = 1'b0;
   end
   // alternate clock, period fourteen core cycles, far below core rate
   always begin
      repeat (7) @(posedge core_clk);
      #1 alt_clk = ~alt_clk;
   end
   // n back-to-back pulses of event k, then release
   task automatic send(input int k, input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1 ev = 11'h001 << k;
      end
      @(posedge core_clk);
      #1 ev = '0;
   endtask : send
endmodule : can_node_model

// ===== verif/test_can_status_count_baud_config.sv
// Purpose: directed register and event test of the status block
// Assumes: strobes and events move #1 after the rising edge
// Notes:   tq periods are measured tick to tick after settling
`timescale 1ns/1ps
module test_can_status_count_baud_config;
   logic        core_clk, rstn, cpu_wr, cpu_rd, init_request, activity_idle;
   logic        prescaler_wide_mode, alt_clk, error_irq_q, init_force_q;
   logic        keep_send_request_q, retransmit_q, rx_flags_block_q, rx_drop_q;
   logic        ctrl_clk_en_q, tq_tick_q;
   logic [1:0]  prescale_upper;
   logic [15:0] cpu_addr;
   logic [7:0]  cpu_wdata, cpu_rdata_q, d;
   logic [10:0] ev;
   logic [4:0]  rx_buffer_count_q;
   int          bad_count, check_count, n, m;
   logic [7:0]  cfg [6] = '{8'h01, 8'h41, 8'h81, 8'hC1, 8'h3F, 8'h02};
   int          per [6] = '{4, 8, 16, 56, 128, 67};
   int          tqc [6] = '{4, 4, 4, 4, 128, 67};

   can_status_count_baud_config uut (
      .core_clk, .rstn, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata_q, .init_request,
      .activity_idle, .wake_event(ev[0]), .valid_event(ev[1]), .tx_fetch_overrun(ev[2]),
      .rx_store_overrun(ev[3]), .id_fetch_overrun(ev[4]), .tx_error(ev[5]), .tx_success(ev[6]),
      .rx_error(ev[7]), .rx_error_big(ev[8]), .rx_success(ev[9]), .bus_idle_recovered(ev[10]),
      .prescaler_wide_mode, .prescale_upper, .alternate_clock_input(alt_clk), .error_irq_q,
      .init_force_q, .keep_send_request_q, .retransmit_q, .rx_flags_block_q, .rx_drop_q,
      .rx_buffer_count_q, .ctrl_clk_en_q, .tq_tick_q);
   can_node_model node (.core_clk, .ev, .alt_clk);

   // clock and a hang limit well above the test's run length
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;
   initial begin
      #500000;
      bad_count++;
      close_out();
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   // read strobe for one edge; data is registered at that edge
   task automatic rd(input logic [15:0] a);
      @(posedge core_clk);
      #1 cpu_addr = a;
      cpu_rd = 1'b1;
      @(posedge core_clk);
      #1 cpu_rd = 1'b0;
      d = cpu_rdata_q;
   endtask : rd
   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, d);
   endtask : rc
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge core_clk);
      #1 cpu_addr = a;
      cpu_wdata = v;
      cpu_wr = 1'b1;
      @(posedge core_clk);
      #1 cpu_wr = 1'b0;
   endtask : wr
   // tick to tick count and controller enables in that span; the first two
   // ticks may still follow the old setting, so only the third span counts
   task automatic gap();
      repeat (3) begin
         n = 0;
         m = 0;
         do begin
            @(posedge core_clk);
            #1 n++;
            if (ctrl_clk_en_q === 1'b1) begin
               m++;
            end
         end while (tq_tick_q !== 1'b1 && n < 400);
         if (n >= 400) begin
            bad_count++;
            close_out();
         end
      end
   endtask : gap

   // main sequence: reset, flags, overruns, counters, buffer count, quanta, bus-off
   initial begin
      {rstn, cpu_wr, cpu_rd, init_request, activity_idle, prescaler_wide_mode} = '0;
      prescale_upper = 2'b01;
      cpu_addr = '0;
      cpu_wdata = '0;
      repeat (6) @(posedge core_clk);
      #1 rstn = 1'b1;
      rc(16'hFFB7, 8'hC0);
      rc(16'hFFB8, 8'h3F);
      rc(16'hFFB5, 8'h00);
      rc(16'hFFB6, 8'h00);
      rc(16'hFFB0, 8'h00);
      wr(16'hFFB7, 8'hC5);
      wr(16'hFFB8, 8'h00);
      rc(16'hFFB7, 8'hC0);
      rc(16'hFFB8, 8'h3F);
      $display("test reset done");
      node.send(0, 1);
      chk("irq", 8'h01, 8'(error_irq_q));
      wr(16'hFFB4, 8'hFD);
      rc(16'hFFB4, 8'h02);
      wr(16'hFFB4, 8'h02);
      rc(16'hFFB4, 8'h00);
      node.send(0, 1);
      init_request = 1'b1;
      rc(16'hFFB4, 8'h00);
      activity_idle = 1'b1;
      rc(16'hFFB4, 8'h08);
      node.send(1, 1);
      rc(16'hFFB4, 8'h0C);
      wr(16'hFFB4, 8'h04);
      rc(16'hFFB4, 8'h08);
      $display("test wake done");
      node.send(2, 1);
      chk("resend", 8'h01, 8'(retransmit_q));
      chk("keep", 8'h01, 8'(keep_send_request_q));
      chk("irq", 8'h01, 8'(error_irq_q));
      node.send(3, 1);
      chk("block", 8'h01, 8'(rx_flags_block_q));
      node.send(4, 1);
      chk("drop", 8'h01, 8'(rx_drop_q));
      fork
         wr(16'hFFB4, 8'h01);
         node.send(2, 1);
      join
      rc(16'hFFB4, 8'h09);
      wr(16'hFFB4, 8'h01);
      chk("irq", 8'h00, 8'(error_irq_q));
      $display("test overrun done");
      node.send(5, 2);
      node.send(6, 1);
      chk("keep", 8'h00, 8'(keep_send_request_q));
      node.send(8, 1);
      node.send(7, 1);
      node.send(9, 1);
      wr(16'hFFB5, 8'h55);
      wr(16'hFFB6, 8'h55);
      rc(16'hFFB5, 8'h0F);
      rc(16'hFFB6, 8'h08);
      node.send(5, 10);
      rc(16'hFFB4, 8'h08);
      node.send(5, 1);
      rc(16'hFFB4, 8'h28);
      $display("test counters done");
      wr(16'hFFB7, 8'hDF);
      rc(16'hFFB7, 8'hD0);
      chk("count", 8'h10, 8'(rx_buffer_count_q));
      wr(16'hFFB7, 8'hC1);
      rc(16'hFFB7, 8'hC1);
      for (int i = 0; i < 6; i++) begin
         prescaler_wide_mode = (i == 5);
         wr(16'hFFB8, cfg[i]);
         gap();
         chk("tq period", per[i][7:0], n[7:0]);
         chk("enables per tq", tqc[i][7:0], m[7:0]);
      end
      $display("test buffers and quanta done");
      node.send(5, 20);
      rd(16'hFFB4);
      chk("bus off", 8'h01, 8'(d[7]));
      wr(16'hFFB7, 8'hE1);
      chk("pm reset", 8'h01, 8'(init_force_q));
      rc(16'hFFB5, 8'h00);
      rc(16'hFFB6, 8'h00);
      rc(16'hFFB4, 8'h08);
      rc(16'hFFB7, 8'hC1);
      $display("test bus-off done");
      node.send(5, 32);
      rc(16'hFFB4, 8'hA8);
      node.send(10, 1);
      rc(16'hFFB4, 8'h08);
      rc(16'hFFB5, 8'h00);
      $display("test bus idle done");
      close_out();
   end
endmodule : test_can_status_count_baud_config
